// >>> fls_checker.sv
// Purpose: port assertions for the fault loop selector
// Assumes: loop order L1-E, L2-E, L3-E, L1-L2, L2-L3, L3-L1
// Notes: the kept set always holds the true minimum, so the margin is rebuilt from it
`timescale 1ns/1ps
module fls_checker #(
    parameter ZW = 16
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Loop inputs
    input wire [5:0] loop_pickup,
    input wire [5:0] loop_in_zone,
    input wire [5:0] loop_replica_ok,
    input wire [6*ZW-1:0] loop_imp,
    input wire [2:0] phase_above_min,
    input wire earth_fault_det,
    // Results and read port
    input wire [5:0] valid_loops_q,
    input wire [2:0] faulted_phase_q,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid
);
    logic [6*ZW-1:0] imp_p;
    logic [5:0] rep_p;
    logic [ZW-1:0] zmin;
    logic rel_ok;
    wire [5:0] v = valid_loops_q;
    always @(posedge aclk) begin
        imp_p <= loop_imp;
        rep_p <= loop_replica_ok;
    end
    // Two extra bits so 3 x minimum cannot wrap
    always_comb begin
        zmin = '1;
        rel_ok = 1'b1;
        for (int k = 0; k < 6; k++)
            if (v[k] && imp_p[k*ZW+:ZW] < zmin) zmin = imp_p[k*ZW+:ZW];
        for (int k = 0; k < 6; k++)
            if (v[k] && !rep_p[k] && {1'b0, imp_p[k*ZW+:ZW], 1'b0} >
                {2'b00, zmin} + {1'b0, zmin, 1'b0}) rel_ok = 1'b0;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_clear: assert property (disable iff (1'b0)
        !aresetn |=> v == 6'h00 && faulted_phase_q == 3'h0) else $error("outputs not cleared");
    chk_phase_map: assert property (
        faulted_phase_q == {|(v & 6'h34), |(v & 6'h1a), |(v & 6'h29)}) else $error("bad phases");
    chk_need_pickup: assert property ((v & ~$past(loop_pickup)) == 6'h00)
        else $error("unpicked loop kept");
    chk_need_zone: assert property (v != 6'h00 |-> (v & ~$past(loop_in_zone)) == 6'h00)
        else $error("loop outside zone kept");
    chk_earth_ok: assert property (|v[2:0] |-> $past(earth_fault_det) &&
        (v[2:0] & ~$past(phase_above_min)) == 3'h0) else $error("earth loop not eligible");
    chk_pair_ok: assert property (|v[5:3] |->
        ({v[5] | v[4], v[4] | v[3], v[5] | v[3]} & ~$past(phase_above_min)) == 3'h0)
        else $error("phase loop not eligible");
    chk_rel_margin: assert property (rel_ok) else $error("loop above margin kept");
    chk_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cov_double_earth: cover property (v == 6'h0a);
    cov_three_phase: cover property (v == 6'h3f);
    cov_margin_drop: cover property (v == 6'h28);
endmodule
bind fls_fault_loop_selector fls_checker #(.ZW(ZW)) i_chk (
    .aclk, .aresetn, .loop_pickup, .loop_in_zone, .loop_replica_ok, .loop_imp,
    .phase_above_min, .earth_fault_det, .valid_loops_q, .faulted_phase_q,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// >>> fls_consts.vh
// Purpose: shared constants of the fault loop selector
// Assumes: loop order L1-E, L2-E, L3-E, L1-L2, L2-L3, L3-L1 in all six-bit vectors
// Notes: byte offsets on the AXI4-Lite register port
`ifndef FLS_CONSTS_VH
`define FLS_CONSTS_VH

// Register byte offsets
`define FLS_CTRL_OFFS 4'h0
`define FLS_STAT_OFFS 4'h4

// Control register fields
`define FLS_CTRL_EARTHED_BIT 0
`define FLS_CTRL_IMPMODE_BIT 1
`define FLS_CTRL_RESTR_LSB 4
`define FLS_CTRL_PREF_LSB 8

// Status register fields
`define FLS_STAT_LOOP_LSB 0
`define FLS_STAT_PHASE_LSB 8

// Control reset values
`define FLS_RST_EARTHED 1'b1
`define FLS_RST_IMPMODE 1'b1
`define FLS_RST_RESTR 3'h0
`define FLS_RST_PREF 4'h8

// Double earth fault restriction codes, earthed networks
`define FLS_RESTR_BLK_LEAD 3'h0
`define FLS_RESTR_BLK_LAG 3'h1
`define FLS_RESTR_ALL 3'h2
`define FLS_RESTR_PP_ONLY 3'h3
`define FLS_RESTR_PE_ONLY 3'h4

// Phase preference codes, non-earthed networks
`define FLS_PREF_A31 4'h0
`define FLS_PREF_A13 4'h1
`define FLS_PREF_A21 4'h2
`define FLS_PREF_A12 4'h3
`define FLS_PREF_A32 4'h4
`define FLS_PREF_A23 4'h5
`define FLS_PREF_C31 4'h6
`define FLS_PREF_C13 4'h7
`define FLS_PREF_ALL 4'h8

// Relative impedance margin: keep if 2*Z <= 3*Zmin (50 % above minimum)
`define FLS_MARGIN_NUM 2'h3
`define FLS_MARGIN_DEN 2'h2

// AXI responses
`define FLS_RESP_OKAY 2'h0
`define FLS_RESP_SLVERR 2'h2

`endif

// >>> fls_fault_loop_selector.v
// Purpose: decide which of six measuring loops stay valid, and the faulted phases
// Assumes: all loop inputs come from logic on aclk; impedance arithmetic done upstream
// Notes: settings and results reached over AXI4-Lite; results registered once
`timescale 1ns/1ps
`include "fls_consts.vh"

module fls_fault_loop_selector #(
    parameter ZW = 16
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Loop inputs from pickup and impedance stages
    input wire [5:0] loop_pickup,
    input wire [5:0] loop_in_zone,
    input wire [5:0] loop_replica_ok,
    input wire [5:0] loop_dir_fwd,
    input wire [6*ZW-1:0] loop_imp,
    input wire [2:0] phase_above_min,
    input wire earth_fault_det,
    input wire earth_current_pickup,
    // Results
    output reg [5:0] valid_loops_q,
    output reg [2:0] faulted_phase_q,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // Settings
    reg earthed_q;
    reg imp_mode_q;
    reg [2:0] restr_q;
    reg [3:0] pref_q;

    // Write channel capture
    reg aw_got_q;
    reg w_got_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    // Kept earth phase per pair under a one-location preference
    function [1:0] pref_phase;
        input [3:0] pref;
        input [1:0] pair;
        reg [5:0] tbl;
        begin
            tbl = 6'h00;
            // Packed as {pair L3/L1, pair L2/L3, pair L1/L2}, phase index 0..2
            case (pref)
                `FLS_PREF_A31: tbl = {2'd2, 2'd2, 2'd0};
                `FLS_PREF_A13: tbl = {2'd0, 2'd2, 2'd0};
                `FLS_PREF_A21: tbl = {2'd0, 2'd1, 2'd1};
                `FLS_PREF_A12: tbl = {2'd0, 2'd1, 2'd0};
                `FLS_PREF_A32: tbl = {2'd2, 2'd2, 2'd1};
                `FLS_PREF_A23: tbl = {2'd2, 2'd1, 2'd1};
                `FLS_PREF_C31: tbl = {2'd2, 2'd1, 2'd0};
                `FLS_PREF_C13: tbl = {2'd0, 2'd2, 2'd1};
                default: tbl = {2'd2, 2'd1, 2'd0};
            endcase
            case (pair)
                2'd0: pref_phase = tbl[1:0];
                2'd1: pref_phase = tbl[3:2];
                default: pref_phase = tbl[5:4];
            endcase
        end
    endfunction

    // Eligibility and release
    wire [5:0] eligible;
    wire [5:0] released;
    wire [5:0] cand;
    assign eligible = {phase_above_min[2] & phase_above_min[0],
                       phase_above_min[1] & phase_above_min[2],
                       phase_above_min[0] & phase_above_min[1],
                       phase_above_min & {3{earth_fault_det}}};
    assign released = imp_mode_q ? 6'h3f : loop_pickup;
    assign cand = released & eligible & loop_pickup;

    // Double earth fault and three-phase restriction
    reg [5:0] sel;
    reg [1:0] pair;
    reg dbl;
    reg [1:0] keep_ph;
    reg [1:0] lead_ph;
    reg [1:0] lag_ph;
    always @* begin
        sel = cand;
        pair = 2'd0;
        dbl = 1'b0;
        keep_ph = 2'd0;
        lead_ph = 2'd0;
        lag_ph = 2'd0;
        case (cand[2:0])
            3'b011: begin
                dbl = 1'b1;
                pair = 2'd0;
            end
            3'b110: begin
                dbl = 1'b1;
                pair = 2'd1;
            end
            3'b101: begin
                dbl = 1'b1;
                pair = 2'd2;
            end
            default: dbl = 1'b0;
        endcase
        // Pair p: leading earth loop is phase p, lagging is p+1, or phase 0 for pair 2
        lead_ph = pair;
        lag_ph = (pair == 2'd2) ? 2'd0 : pair + 2'd1;
        if (cand[5:3] == 3'b111) begin
            // Earth loops already need earth detection via eligibility
            sel = {3'b111, cand[2:0] & {3{earth_fault_det}}};
        end else if (earthed_q) begin
            if (dbl && cand[3 + pair] &&
                loop_dir_fwd[lag_ph] == loop_dir_fwd[lead_ph] &&
                loop_dir_fwd[lag_ph] == loop_dir_fwd[3 + pair]) begin
                case (restr_q)
                    `FLS_RESTR_BLK_LEAD: sel[lead_ph] = 1'b0;
                    `FLS_RESTR_BLK_LAG: sel[lag_ph] = 1'b0;
                    `FLS_RESTR_PP_ONLY: sel[2:0] = 3'b000;
                    `FLS_RESTR_PE_ONLY: sel[3 + pair] = 1'b0;
                    default: sel = cand;
                endcase
            end
        end else begin
            if (!earth_current_pickup) begin
                // Zero-sequence shift alone must not trip
                sel[2:0] = 3'b000;
            end else if (dbl) begin
                if (pref_q == `FLS_PREF_ALL || pref_q > `FLS_PREF_ALL) begin
                    sel = 6'h00;
                    sel[lag_ph] = 1'b1;
                    sel[lead_ph] = 1'b1;
                end else begin
                    // Second location is left to earth fault detection elsewhere
                    keep_ph = pref_phase(pref_q, pair);
                    sel = 6'h00;
                    sel[keep_ph] = 1'b1;
                end
            end
        end
    end

    // Smallest impedance among in-zone selected loops
    wire [5:0] zone_sel;
    assign zone_sel = sel & loop_in_zone;
    reg [ZW-1:0] zmin;
    integer k;
    always @* begin
        zmin = {ZW{1'b1}};
        for (k = 0; k < 6; k = k + 1) begin
            if (zone_sel[k] && loop_imp[k*ZW +: ZW] < zmin) begin
                zmin = loop_imp[k*ZW +: ZW];
            end
        end
    end

    // Per-loop verification
    wire [5:0] valid_d;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_loop
            wire [ZW+1:0] z_scaled;
            wire [ZW+1:0] lim;
            wire definite;
            assign definite = loop_replica_ok[g];
            assign z_scaled = {2'b00, loop_imp[g*ZW +: ZW]} * `FLS_MARGIN_DEN;
            assign lim = {2'b00, zmin} * `FLS_MARGIN_NUM;
            assign valid_d[g] = zone_sel[g] & (definite | (z_scaled <= lim));
        end
    endgenerate

    wire [2:0] phase_d;
    assign phase_d = valid_d[2:0] |
                     {valid_d[4] | valid_d[5], valid_d[3] | valid_d[4],
                      valid_d[3] | valid_d[5]};

    always @(posedge aclk) begin
        if (!aresetn) begin
            valid_loops_q <= 6'h00;
            faulted_phase_q <= 3'h0;
        end else begin
            valid_loops_q <= valid_d;
            faulted_phase_q <= phase_d;
        end
    end

    // AXI4-Lite write path; address and data may arrive in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FLS_RESP_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            earthed_q <= `FLS_RST_EARTHED;
            imp_mode_q <= `FLS_RST_IMPMODE;
            restr_q <= `FLS_RST_RESTR;
            pref_q <= `FLS_RST_PREF;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_got_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_got_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_q && w_got_q && !s_axi_bvalid) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if ({awaddr_q[3:2], 2'b00} == `FLS_CTRL_OFFS) begin
                    s_axi_bresp <= `FLS_RESP_OKAY;
                    if (wstrb_q[0]) begin
                        earthed_q <= wdata_q[`FLS_CTRL_EARTHED_BIT];
                        imp_mode_q <= wdata_q[`FLS_CTRL_IMPMODE_BIT];
                        restr_q <= wdata_q[`FLS_CTRL_RESTR_LSB +: 3];
                    end
                    if (wstrb_q[1]) begin
                        pref_q <= wdata_q[`FLS_CTRL_PREF_LSB +: 4];
                    end
                end else if ({awaddr_q[3:2], 2'b00} == `FLS_STAT_OFFS) begin
                    // Status is read-only; write dropped quietly
                    s_axi_bresp <= `FLS_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `FLS_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read path, one outstanding read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FLS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `FLS_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                if ({s_axi_araddr[3:2], 2'b00} == `FLS_CTRL_OFFS) begin
                    s_axi_rdata[`FLS_CTRL_EARTHED_BIT] <= earthed_q;
                    s_axi_rdata[`FLS_CTRL_IMPMODE_BIT] <= imp_mode_q;
                    s_axi_rdata[`FLS_CTRL_RESTR_LSB +: 3] <= restr_q;
                    s_axi_rdata[`FLS_CTRL_PREF_LSB +: 4] <= pref_q;
                end else if ({s_axi_araddr[3:2], 2'b00} == `FLS_STAT_OFFS) begin
                    s_axi_rdata[`FLS_STAT_LOOP_LSB +: 6] <= valid_loops_q;
                    s_axi_rdata[`FLS_STAT_PHASE_LSB +: 3] <= faulted_phase_q;
                end else begin
                    s_axi_rresp <= `FLS_RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// >>> fls_pickup_model.sv
// Purpose: upstream pickup and impedance stage for the selector bench
// Assumes: commands change just after a clock edge
// Notes: unpicked loops carry a toggling impedance, never a stale one
`timescale 1ns/1ps
module fls_pickup_model #(
    parameter ZW = 16
) (
    // Clock
    input wire aclk,
    // Commands
    input wire [5:0] pick,
    input wire [5:0] zone,
    input wire [5:0] rep,
    input wire [5:0] rev,
    input wire [5:0] far,
    input wire [2:0] lowph,
    input wire [ZW-1:0] z,
    input wire [ZW-1:0] step,
    // Loop outputs
    output logic [5:0] loop_pickup,
    output logic [5:0] loop_in_zone,
    output logic [5:0] loop_replica_ok,
    output logic [5:0] loop_dir_fwd,
    output logic [6*ZW-1:0] loop_imp,
    output logic [2:0] phase_above_min
);
    logic [ZW-1:0] junk = '0;
    always @(posedge aclk) begin
        junk <= ~junk;
        loop_pickup <= pick;
        loop_in_zone <= zone & pick;
        loop_replica_ok <= rep & pick;
        loop_dir_fwd <= ~rev;
        phase_above_min <= {|(pick & 6'h34), |(pick & 6'h1a), |(pick & 6'h29)} & ~lowph;
        for (int k = 0; k < 6; k++)
            loop_imp[k*ZW+:ZW] <= !pick[k] ? junk : far[k] ? z + step : z;
    end
endmodule

// >>> test_fault_loop_selector.sv
// Purpose: self-checking bench for the fault loop selector
// Assumes: settings reach the block over AXI4-Lite only
// Notes: loop inputs pass the pickup model, so results land two edges later
`timescale 1ns/1ps
`include "fls_consts.vh"
module test_fault_loop_selector;
    localparam int ZW = 16;
    localparam logic [31:0] CTRL_RST = {20'h0, `FLS_RST_PREF, 1'b0, `FLS_RST_RESTR, 2'b00,
        `FLS_RST_IMPMODE, `FLS_RST_EARTHED};
    logic aclk = 1'b0, aresetn = 1'b0, efd = 1'b1, ecp = 1'b1;
    logic [5:0] pick = 6'h00, zone = 6'h3f, rep = 6'h00, rev = 6'h00, far = 6'h00;
    logic [2:0] lowph = 3'h0;
    logic [ZW-1:0] z = 16'h0064, step = 16'h0032;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [5:0] vq, lp, lz, lr, ld;
    wire [2:0] fq, pa;
    wire [6*ZW-1:0] li;
    int mismatches = 0, checked = 0;
    always #5 aclk = ~aclk;
    fls_pickup_model #(.ZW(ZW)) i_model (.aclk(aclk), .pick(pick), .zone(zone), .rep(rep),
        .rev(rev), .far(far), .lowph(lowph), .z(z), .step(step), .loop_pickup(lp),
        .loop_in_zone(lz), .loop_replica_ok(lr), .loop_dir_fwd(ld), .loop_imp(li),
        .phase_above_min(pa));
    fls_fault_loop_selector #(.ZW(ZW)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .loop_pickup(lp), .loop_in_zone(lz), .loop_replica_ok(lr), .loop_dir_fwd(ld),
        .loop_imp(li), .phase_above_min(pa), .earth_fault_det(efd),
        .earth_current_pickup(ecp), .valid_loops_q(vq), .faulted_phase_q(fq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic bad(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Opening edge keeps a released valid from being raised in the same step
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 40);
        bready <= 1'b0;
        checked++;
        if (bresp !== er || n >= 40) bad("write response");
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 40);
        rready <= 1'b0;
        checked++;
        if (rdata !== ed || rresp !== er || n >= 40) bad("read data");
    endtask
    task automatic set_ctrl(input logic e, input logic [2:0] r, input logic [3:0] p);
        axi_wr(`FLS_CTRL_OFFS, {20'h0, p, 1'b0, r, 3'b001, e}, `FLS_RESP_OKAY);
    endtask
    task automatic run(input logic [5:0] p, input logic [5:0] e);
        pick <= p;
        repeat (3) @(posedge aclk);
        checked++;
        if (vq !== e || fq !== {|(e & 6'h34), |(e & 6'h1a), |(e & 6'h29)}) bad("loop result");
    endtask
    task automatic t_regs;
        axi_rd(`FLS_CTRL_OFFS, CTRL_RST, `FLS_RESP_OKAY);
        axi_rd(4'h8, 32'h0, `FLS_RESP_SLVERR);
        axi_wr(4'hc, 32'h0, `FLS_RESP_SLVERR);
        axi_wr(`FLS_STAT_OFFS, 32'hffff_ffff, `FLS_RESP_OKAY);
        axi_rd(`FLS_CTRL_OFFS, CTRL_RST, `FLS_RESP_OKAY);
    endtask
    task automatic t_earthed;
        logic [5:0] pk [3] = '{6'h0b, 6'h16, 6'h25};
        logic [5:0] ex [15] = '{6'h0a, 6'h09, 6'h0b, 6'h08, 6'h03, 6'h14, 6'h12, 6'h16,
            6'h10, 6'h06, 6'h21, 6'h24, 6'h25, 6'h20, 6'h05};
        for (int c = 0; c < 5; c++) begin
            set_ctrl(1'b1, 3'(c), `FLS_PREF_ALL);
            for (int p = 0; p < 3; p++) run(pk[p], ex[p*5+c]);
        end
        rev <= 6'h02;
        run(6'h0b, 6'h0b);
        axi_rd(`FLS_STAT_OFFS, 32'h0000_030b, `FLS_RESP_OKAY);
        rev <= 6'h00;
    endtask
    task automatic t_nonearth;
        logic [11:0] pref_tab [9] = '{12'h144, 12'h141, 12'h221, 12'h121, 12'h244, 12'h224,
            12'h124, 12'h241, 12'h365};
        logic [5:0] pk [3] = '{6'h0b, 6'h16, 6'h25};
        for (int c = 0; c < 9; c++) begin
            set_ctrl(1'b0, `FLS_RESTR_BLK_LEAD, 4'(c));
            for (int p = 0; p < 3; p++) run(pk[p], {3'b000, pref_tab[c][8-4*p+:3]});
        end
        ecp <= 1'b0;
        run(6'h02, 6'h00);
        ecp <= 1'b1;
        run(6'h02, 6'h02);
    endtask
    task automatic t_three;
        set_ctrl(1'b1, `FLS_RESTR_ALL, `FLS_PREF_ALL);
        efd <= 1'b0;
        run(6'h3f, 6'h38);
        efd <= 1'b1;
        run(6'h3f, 6'h3f);
    endtask
    // Exactly 50 % above the minimum stays, one step more is dropped
    task automatic t_margin;
        far <= 6'h10;
        run(6'h38, 6'h38);
        step <= 16'h0033;
        run(6'h38, 6'h28);
        rep <= 6'h10;
        run(6'h38, 6'h38);
        zone <= 6'h18;
        run(6'h38, 6'h18);
        zone <= 6'h3f;
        rep <= 6'h00;
        far <= 6'h00;
    endtask
    task automatic t_elig;
        efd <= 1'b0;
        run(6'h01, 6'h00);
        efd <= 1'b1;
        lowph <= 3'h1;
        run(6'h01, 6'h00);
        lowph <= 3'h2;
        run(6'h08, 6'h00);
        lowph <= 3'h0;
        run(6'h08, 6'h08);
    endtask
    task automatic t_reset;
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        checked++;
        if (vq !== 6'h00 || fq !== 3'h0) bad("outputs after reset");
        axi_rd(`FLS_CTRL_OFFS, CTRL_RST, `FLS_RESP_OKAY);
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_earthed;
        t_nonearth;
        t_three;
        t_margin;
        t_elig;
        t_reset;
        print_verdict;
    end
    initial begin
        #200000;
        bad("timeout");
        print_verdict;
    end
endmodule
